// *** include/video_port_capture_map.svh ***
// register offsets, field positions, reset values and timing counts of the capture control
// How it works
// RQ1 - bits 4-3 of window control keep every line, or one of two, four, eight
// RQ2 - bit 5 picks odd lines from line one, else even lines from zero
// RQ3 - with mask enable set, stores the mask map forbids are dropped
// RQ4 - polarity bits 0 and 1 invert the two port outputs before driving
// RQ5 - polarity bits 2 to 5 invert the field, vertical, line and enable inputs
// RQ6 - the data-valid input after bit 6 inversion must be active high
// RQ7 - polarity bit 7 marks interlaced input, steering how fields are stored
// RQ8 - software loads a word-aligned 24-bit mask map base, bit zero clear
// RQ9 - next mask line address adds the 8-bit stride in quad words
// RQ10 - software sets mask stride to window width over 64, plus one
// RQ11 - one word-aligned window base serves the input and output paths
// RQ12 - next window line address adds the 8-bit line stride in words
// RQ13 - bits 2-1 keep one of one, two, four or eight pixels per line
// RQ14 - each vertical reset reloads line and mask line addresses from bases
`ifndef VIDEO_PORT_CAPTURE_MAP_SVH
`define VIDEO_PORT_CAPTURE_MAP_SVH

// register offsets
`define VPC_OFS_PORT_STATUS    8'h95
`define VPC_OFS_WIN_CTRL       8'h96
`define VPC_OFS_POLARITY       8'h97
`define VPC_OFS_MASK_BASE0     8'h98
`define VPC_OFS_MASK_BASE1     8'h99
`define VPC_OFS_MASK_BASE2     8'h9A
`define VPC_OFS_MASK_STRIDE    8'h9B
`define VPC_OFS_WIN_BASE0      8'h9C
`define VPC_OFS_WIN_BASE1      8'h9D
`define VPC_OFS_WIN_BASE2      8'h9E
`define VPC_OFS_WIN_STRIDE     8'h9F

// reset values
`define VPC_RST_WIN_CTRL       8'h00
`define VPC_RST_POLARITY       8'h00
`define VPC_RST_PORT_STATUS    8'h00
`define VPC_RST_ADDR           24'h000000
`define VPC_RST_STRIDE         8'h00

// window control fields
`define VPC_WC_ENABLE          0
`define VPC_WC_HSCALE_LO       1
`define VPC_WC_VSCALE_LO       3
`define VPC_WC_VSEL_ODD        5
`define VPC_WC_HSEL_ODD        6
`define VPC_WC_MASK_EN         7

// polarity control fields
`define VPC_PC_OUT_CAPTURE     0
`define VPC_PC_OUT_LINE        1
`define VPC_PC_IN_FIELD        2
`define VPC_PC_IN_VRESET       3
`define VPC_PC_IN_LRESET       4
`define VPC_PC_IN_ENABLE       5
`define VPC_PC_IN_VALID        6
`define VPC_PC_INTERLACED      7

// port status fields
`define VPC_PS_VRESET          0
`define VPC_PS_FIELD           1
`define VPC_PS_BYTE_SWAP       6

// synchroniser depth and pin group width
`define VPC_SYNC_STAGES        2
`define VPC_PIN_WIDTH          21

`endif

// *** include/video_port_pkg.sv ***
// types shared by the video port capture control
package video_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SYNC,
    ST_RUN
  } cap_state_e;

  typedef struct packed {
    logic        wr;
    logic [23:0] addr;
    logic [15:0] data;
  } mem_wr_s;

  typedef struct packed {
    logic [15:0] data;
    logic        valid;
    logic        field;
    logic        vreset;
    logic        lreset;
    logic        enable;
  } port_pins_s;

endpackage

// *** hdl/pin_sync.sv ***
// two-flop synchroniser for a group of port pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  // pins
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule
`default_nettype wire

// *** hdl/video_port_capture_control.sv ***
// capture side of the video input port: decimation, masking, polarity and addressing
`timescale 1ns/1ps
`default_nettype none
`include "video_port_capture_map.svh"
module video_port_capture_control (
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   arst_n_i,
  // register port
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  input  wire logic [7:0]             reg_wdata_i,
  output logic      [7:0]             reg_rdata_o,
  // video port pins
  input  wire logic [15:0]            pix_data_i,
  input  wire logic                   pixel_valid_input_i,
  input  wire logic                   field_id_input_i,
  input  wire logic                   vertical_reset_input_i,
  input  wire logic                   line_reset_input_i,
  input  wire logic                   port_enable_input_i,
  output logic                        capture_active_o,
  output logic                        line_kept_o,
  // display memory
  input  wire logic                   mask_allow_i,
  output video_port_pkg::mem_wr_s     mem_wr_o,
  output logic      [23:0]            mask_line_addr_o
);
  import video_port_pkg::*;

  function automatic logic [2:0] decim_mask(input logic [1:0] code);
    case (code)
      2'h0:    decim_mask = 3'h0;
      2'h1:    decim_mask = 3'h1;
      2'h2:    decim_mask = 3'h3;
      default: decim_mask = 3'h7;
    endcase
  endfunction

  // pin synchronisation
  port_pins_s pins_async;
  port_pins_s pins;

  assign pins_async = '{data:   pix_data_i,
                        valid:  pixel_valid_input_i,
                        field:  field_id_input_i,
                        vreset: vertical_reset_input_i,
                        lreset: line_reset_input_i,
                        enable: port_enable_input_i};

  pin_sync #(
    .WIDTH (`VPC_PIN_WIDTH)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .async_i   (pins_async),
    .sync_o    (pins)
  );

  // register file
  logic [7:0]  win_ctrl_ff,   nxt_win_ctrl;
  logic [7:0]  polarity_ff,   nxt_polarity;
  logic        byte_swap_ff,  nxt_byte_swap;
  logic [23:0] mask_base_ff,  nxt_mask_base;
  logic [7:0]  mask_stride_ff, nxt_mask_stride;
  logic [23:0] win_base_ff,   nxt_win_base;
  logic [7:0]  win_stride_ff, nxt_win_stride;
  logic [7:0]  rdata_ff,      nxt_rdata;

  // polarity-corrected port signals
  logic vrst_act;
  logic lrst_act;
  logic enable_act;
  logic field_odd;
  logic pix_valid;

  always_comb begin
    nxt_win_ctrl    = win_ctrl_ff;
    nxt_polarity    = polarity_ff;
    nxt_byte_swap   = byte_swap_ff;
    nxt_mask_base   = mask_base_ff;
    nxt_mask_stride = mask_stride_ff;
    nxt_win_base    = win_base_ff;
    nxt_win_stride  = win_stride_ff;
    nxt_rdata       = rdata_ff;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `VPC_OFS_PORT_STATUS: nxt_byte_swap = reg_wdata_i[`VPC_PS_BYTE_SWAP];
        `VPC_OFS_WIN_CTRL:    nxt_win_ctrl = reg_wdata_i;
        `VPC_OFS_POLARITY:    nxt_polarity = reg_wdata_i;
        `VPC_OFS_MASK_BASE0:  nxt_mask_base[7:0] = reg_wdata_i;
        `VPC_OFS_MASK_BASE1:  nxt_mask_base[15:8] = reg_wdata_i;
        `VPC_OFS_MASK_BASE2:  nxt_mask_base[23:16] = reg_wdata_i;
        `VPC_OFS_MASK_STRIDE: nxt_mask_stride = reg_wdata_i;
        `VPC_OFS_WIN_BASE0:   nxt_win_base[7:0] = reg_wdata_i;
        `VPC_OFS_WIN_BASE1:   nxt_win_base[15:8] = reg_wdata_i;
        `VPC_OFS_WIN_BASE2:   nxt_win_base[23:16] = reg_wdata_i;
        `VPC_OFS_WIN_STRIDE:  nxt_win_stride = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `VPC_OFS_PORT_STATUS: nxt_rdata = {1'b0, byte_swap_ff, 4'h0, field_odd, vrst_act};
        `VPC_OFS_WIN_CTRL:    nxt_rdata = win_ctrl_ff;
        `VPC_OFS_POLARITY:    nxt_rdata = polarity_ff;
        `VPC_OFS_MASK_BASE0:  nxt_rdata = mask_base_ff[7:0];
        `VPC_OFS_MASK_BASE1:  nxt_rdata = mask_base_ff[15:8];
        `VPC_OFS_MASK_BASE2:  nxt_rdata = mask_base_ff[23:16];
        `VPC_OFS_MASK_STRIDE: nxt_rdata = mask_stride_ff;
        `VPC_OFS_WIN_BASE0:   nxt_rdata = win_base_ff[7:0];
        `VPC_OFS_WIN_BASE1:   nxt_rdata = win_base_ff[15:8];
        `VPC_OFS_WIN_BASE2:   nxt_rdata = win_base_ff[23:16];
        `VPC_OFS_WIN_STRIDE:  nxt_rdata = win_stride_ff;
        default:              nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      win_ctrl_ff    <= `VPC_RST_WIN_CTRL;
      polarity_ff    <= `VPC_RST_POLARITY;
      byte_swap_ff   <= 1'b0;
      mask_base_ff   <= `VPC_RST_ADDR;
      mask_stride_ff <= `VPC_RST_STRIDE;
      win_base_ff    <= `VPC_RST_ADDR;
      win_stride_ff  <= `VPC_RST_STRIDE;
      rdata_ff       <= 8'h00;
    end else begin
      win_ctrl_ff    <= nxt_win_ctrl;
      polarity_ff    <= nxt_polarity;
      byte_swap_ff   <= nxt_byte_swap;
      mask_base_ff   <= nxt_mask_base;
      mask_stride_ff <= nxt_mask_stride;
      win_base_ff    <= nxt_win_base;
      win_stride_ff  <= nxt_win_stride;
      rdata_ff       <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;

  // field, reset and enable inputs default to active low, valid to active high; a set bit flips the sense
  assign field_odd  = ~(pins.field ^ polarity_ff[`VPC_PC_IN_FIELD]);    // RQ5
  assign vrst_act   = ~(pins.vreset ^ polarity_ff[`VPC_PC_IN_VRESET]);  // RQ5
  assign lrst_act   = ~(pins.lreset ^ polarity_ff[`VPC_PC_IN_LRESET]);  // RQ5
  assign enable_act = ~(pins.enable ^ polarity_ff[`VPC_PC_IN_ENABLE]);  // RQ5
  assign pix_valid  = pins.valid ^ polarity_ff[`VPC_PC_IN_VALID];       // RQ6

  // capture state
  cap_state_e  state_ff,     nxt_state;
  logic        vrst_q_ff,    nxt_vrst_q;
  logic        lrst_q_ff,    nxt_lrst_q;
  logic [2:0]  line_cnt_ff,  nxt_line_cnt;
  logic [2:0]  pix_cnt_ff,   nxt_pix_cnt;
  logic [23:0] line_addr_ff, nxt_line_addr;
  logic [23:0] pix_addr_ff,  nxt_pix_addr;
  logic [23:0] mask_addr_ff, nxt_mask_addr;
  mem_wr_s     mem_wr_ff,    nxt_mem_wr;
  logic        cap_out_ff,   nxt_cap_out;
  logic        line_out_ff,  nxt_line_out;

  logic        frame_start;
  logic        line_end;
  logic        line_keep;
  logic        pix_keep;
  logic        pix_take;
  logic        store;
  logic        interlaced;
  logic [2:0]  vmask;
  logic [2:0]  hmask;
  logic [23:0] win_base_w;
  logic [23:0] line_step;
  logic [23:0] mask_step;

  assign frame_start = vrst_act & ~vrst_q_ff;
  assign line_end    = lrst_act & ~lrst_q_ff;
  assign interlaced  = polarity_ff[`VPC_PC_INTERLACED];                   // RQ7
  assign vmask       = decim_mask(win_ctrl_ff[`VPC_WC_VSCALE_LO +: 2]);   // RQ1
  assign hmask       = decim_mask(win_ctrl_ff[`VPC_WC_HSCALE_LO +: 2]);   // RQ13
  // even select starts at line zero, odd at line one, spaced by the factor
  assign line_keep   = (line_cnt_ff & vmask)
                       == ({2'h0, win_ctrl_ff[`VPC_WC_VSEL_ODD]} & vmask); // RQ2
  assign pix_keep    = (pix_cnt_ff & hmask)
                       == ({2'h0, win_ctrl_ff[`VPC_WC_HSEL_ODD]} & hmask); // RQ13
  // bit zero is forced clear so a stray odd base cannot misalign writes
  assign win_base_w  = {win_base_ff[23:1], 1'b0};                         // RQ11
  // interlaced fields interleave, so each field steps two lines
  assign line_step   = interlaced ? {14'h0, win_stride_ff, 2'h0}
                                  : {15'h0, win_stride_ff, 1'b0};         // RQ12
  assign mask_step   = {13'h0, mask_stride_ff, 3'h0};                     // RQ9
  assign pix_take    = (state_ff == ST_RUN) & pix_valid & enable_act & ~vrst_act;
  assign store       = pix_take & line_keep & pix_keep;

  always_comb begin
    nxt_state     = state_ff;
    nxt_vrst_q    = vrst_act;
    nxt_lrst_q    = lrst_act;
    nxt_line_cnt  = line_cnt_ff;
    nxt_pix_cnt   = pix_cnt_ff;
    nxt_line_addr = line_addr_ff;
    nxt_pix_addr  = pix_addr_ff;
    nxt_mask_addr = mask_addr_ff;
    nxt_mem_wr    = '{wr: 1'b0, addr: pix_addr_ff, data: mem_wr_ff.data};
    case (state_ff)
      ST_IDLE: begin
        if (win_ctrl_ff[`VPC_WC_ENABLE]) begin
          nxt_state = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (!win_ctrl_ff[`VPC_WC_ENABLE]) begin
          nxt_state = ST_IDLE;
        end else if (frame_start) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!win_ctrl_ff[`VPC_WC_ENABLE]) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (frame_start) begin
      nxt_line_cnt  = 3'h0;
      nxt_pix_cnt   = 3'h0;
      nxt_line_addr = (interlaced && field_odd) ?
                      24'(win_base_w + {15'h0, win_stride_ff, 1'b0}) : win_base_w; // RQ7 RQ14
      nxt_pix_addr  = nxt_line_addr;
      nxt_mask_addr = {mask_base_ff[23:1], 1'b0};                          // RQ8 RQ14
    end else if (line_end) begin
      nxt_line_cnt = 3'(line_cnt_ff + 3'h1);
      nxt_pix_cnt  = 3'h0;
      if (line_keep) begin
        nxt_line_addr = 24'(line_addr_ff + line_step);                     // RQ12
        nxt_mask_addr = 24'(mask_addr_ff + mask_step);                     // RQ9
      end
      nxt_pix_addr = nxt_line_addr;
    end else if (pix_take) begin
      nxt_pix_cnt = 3'(pix_cnt_ff + 3'h1);
      if (store) begin
        // masked positions still advance so the window stays in register
        nxt_pix_addr = 24'(pix_addr_ff + 24'h000002);
        nxt_mem_wr.wr = ~(win_ctrl_ff[`VPC_WC_MASK_EN] & ~mask_allow_i);    // RQ3
        nxt_mem_wr.data = byte_swap_ff ? {pins.data[7:0], pins.data[15:8]} : pins.data;
      end
    end
    nxt_cap_out  = ~(state_ff == ST_RUN) ^ polarity_ff[`VPC_PC_OUT_CAPTURE];        // RQ4
    nxt_line_out = ((state_ff == ST_RUN) & line_keep) ^ polarity_ff[`VPC_PC_OUT_LINE]; // RQ4
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff     <= ST_IDLE;
      // start as if already asserted: the synchroniser comes out of reset reading
      // asserted, so this keeps that from looking like a frame or line edge
      vrst_q_ff    <= 1'b1;
      lrst_q_ff    <= 1'b1;
      line_cnt_ff  <= 3'h0;
      pix_cnt_ff   <= 3'h0;
      line_addr_ff <= `VPC_RST_ADDR;
      pix_addr_ff  <= `VPC_RST_ADDR;
      mask_addr_ff <= `VPC_RST_ADDR;
      mem_wr_ff    <= '0;
      cap_out_ff   <= 1'b1;
      line_out_ff  <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      vrst_q_ff    <= nxt_vrst_q;
      lrst_q_ff    <= nxt_lrst_q;
      line_cnt_ff  <= nxt_line_cnt;
      pix_cnt_ff   <= nxt_pix_cnt;
      line_addr_ff <= nxt_line_addr;
      pix_addr_ff  <= nxt_pix_addr;
      mask_addr_ff <= nxt_mask_addr;
      mem_wr_ff    <= nxt_mem_wr;
      cap_out_ff   <= nxt_cap_out;
      line_out_ff  <= nxt_line_out;
    end
  end

  assign capture_active_o = cap_out_ff;
  assign line_kept_o      = line_out_ff;
  assign mem_wr_o         = mem_wr_ff;
  assign mask_line_addr_o = mask_addr_ff;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  line_keep_all_a: assert property (win_ctrl_ff[4:3] == 2'h0 |-> line_keep) // RQ1
    else $error("line dropped with vertical scaling off");
  line_div8_a: assert property (win_ctrl_ff[4:3] == 2'h3 && line_keep
                                |-> line_cnt_ff[1:0] == 2'h0
                                    || line_cnt_ff == {2'h0, win_ctrl_ff[5]}) // RQ1
    else $error("wrong line kept at divide by eight");
  line_select_a: assert property (win_ctrl_ff[4:3] == 2'h1 && line_keep
                                  |-> line_cnt_ff[0] == win_ctrl_ff[5]) // RQ2
    else $error("even or odd line select broken");
  mask_block_a: assert property (store && win_ctrl_ff[7] && !mask_allow_i
                                 |=> !mem_wr_o.wr) // RQ3
    else $error("masked pixel was written");
  out_polarity_a: assert property (##1 capture_active_o
                                   == (($past(state_ff) != ST_RUN) ^ $past(polarity_ff[0]))) // RQ4
    else $error("capture output polarity wrong");
  valid_gate_a: assert property (!pix_valid |=> !mem_wr_o.wr) // RQ6
    else $error("write without valid data");
  field_offset_a: assert property (frame_start && interlaced && field_odd
                                   |=> line_addr_ff == 24'($past(win_base_w)
                                       + {15'h0, $past(win_stride_ff), 1'b0})) // RQ7
    else $error("odd field not offset by one line");
  mask_stride_a: assert property (line_end && !frame_start && line_keep
                                  |=> mask_line_addr_o == 24'($past(mask_addr_ff)
                                      + {13'h0, $past(mask_stride_ff), 3'h0})) // RQ9
    else $error("mask line address step wrong");
  line_stride_a: assert property (line_end && !frame_start && line_keep && !interlaced
                                  |=> line_addr_ff == 24'($past(line_addr_ff)
                                      + {15'h0, $past(win_stride_ff), 1'b0})) // RQ12
    else $error("window line address step wrong");
  pix_decim_a: assert property (mem_wr_o.wr |-> $past(pix_keep) && $past(line_keep)) // RQ13
    else $error("write of a decimated pixel");
  frame_reload_a: assert property (frame_start
                                   |=> mask_line_addr_o == {$past(mask_base_ff[23:1]), 1'b0}) // RQ14
    else $error("mask address not reloaded at frame start");

  frame_run_c: cover property (state_ff == ST_SYNC && frame_start ##1 state_ff == ST_RUN);
  pixel_write_c: cover property (mem_wr_o.wr);
  masked_drop_c: cover property (store && win_ctrl_ff[7] && !mask_allow_i);
  odd_field_c: cover property (frame_start && interlaced && field_odd);

endmodule
`default_nettype wire

// *** test/video_source_model.sv ***
// video decoder model that drives the capture port pins frame by frame
`timescale 1ns/1ps
`default_nettype none
module video_source_model (
  // clock
  input  wire logic        clk_sys_i,
  // pin polarity and pixel data key
  input  wire logic [7:0]  pol_i,
  input  wire logic [15:0] key_i,
  // port pins
  output logic      [15:0] pix_data_o,
  output logic             valid_o,
  output logic             field_o,
  output logic             vreset_o,
  output logic             lreset_o,
  output logic             enable_o
);
  logic busy;

  initial begin
    busy = 1'b0;
    pix_data_o = 16'h5AA5;
    valid_o = 1'b0;
    field_o = 1'b0;
    vreset_o = 1'b1;
    lreset_o = 1'b1;
    enable_o = 1'b1;
  end

  // data lines carry nothing outside valid cycles, so they keep changing
  always @(posedge clk_sys_i) begin
    if (!busy) pix_data_o <= ~pix_data_o;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic frame(input int nl, input int np, input logic odd, input logic slow);
    int l;
    int p;
    field_o = ~odd ^ pol_i[2];
    valid_o = pol_i[6];
    lreset_o = ~pol_i[4];
    enable_o = ~pol_i[5];
    vreset_o = ~pol_i[3];
    step(4);
    vreset_o = pol_i[3];
    step(4);
    vreset_o = ~pol_i[3];
    step(4);
    for (l = 0; l < nl; l++) begin
      for (p = 0; p < np; p++) begin
        enable_o = pol_i[5];
        valid_o = ~pol_i[6];
        busy = 1'b1;
        pix_data_o = key_i ^ {l[7:0], p[7:0]};
        step(1);
        if (slow) begin
          busy = 1'b0;
          valid_o = pol_i[6];
          step(1);
        end
      end
      busy = 1'b0;
      enable_o = ~pol_i[5];
      valid_o = pol_i[6];
      lreset_o = pol_i[4];
      step(2);
      lreset_o = ~pol_i[4];
      step(2);
    end
  endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the video port capture control
`timescale 1ns/1ps
`default_nettype none
`include "video_port_capture_map.svh"
module testbench;
  import video_port_pkg::*;
  int          seed, errors, checks, nl, np, kl;
  logic [31:0] r, r2, r3;
  logic [7:0]  pol, ms, ws, reg_addr, reg_wdata, reg_rdata;
  logic [23:0] mb, wb, mask_line_addr;
  logic [15:0] key, pix_data;
  logic [1:0]  vs, hs;
  logic        vsel, hsel, men, allow, slow, odd, mask_allow, swp;
  logic        clk_sys, arst_n, reg_wr, reg_rd, valid, field, vreset, lreset, enable;
  logic        capture_active, line_kept;
  mem_wr_s     mem_wr;
  logic [39:0] exp_q[$];

  video_port_capture_control dut (
    .clk_sys_i(clk_sys), .arst_n_i(arst_n),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .pix_data_i(pix_data), .pixel_valid_input_i(valid), .field_id_input_i(field),
    .vertical_reset_input_i(vreset), .line_reset_input_i(lreset),
    .port_enable_input_i(enable), .capture_active_o(capture_active),
    .line_kept_o(line_kept), .mask_allow_i(mask_allow), .mem_wr_o(mem_wr),
    .mask_line_addr_o(mask_line_addr)
  );

  video_source_model src (
    .clk_sys_i(clk_sys), .pol_i(pol), .key_i(key), .pix_data_o(pix_data),
    .valid_o(valid), .field_o(field), .vreset_o(vreset), .lreset_o(lreset),
    .enable_o(enable)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask

  task automatic wr24(input logic [7:0] a, input logic [23:0] d);
    wr(a, d[7:0]);
    wr(8'(a + 1), d[15:8]);
    wr(8'(a + 2), d[23:16]);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    chk(reg_rdata, e, "register read");
  endtask

  // notes every store the coming frame should produce, in order
  task automatic expect_frame;
    int a, vm, hm, l, p;
    logic [15:0] d;
    vm = (1 << vs) - 1;
    hm = (1 << hs) - 1;
    kl = 0;
    for (l = 0; l < nl; l++) begin
      if ((l & vm) == (vsel & vm)) begin
        a = wb + ((pol[7] && odd) ? 2 * ws : 0) + kl * (pol[7] ? 4 : 2) * ws;
        for (p = 0; p < np; p++) begin
          if ((p & hm) == (hsel & hm)) begin
            d = key ^ {l[7:0], p[7:0]};
            if (swp) d = {d[7:0], d[15:8]};
            if (!men || allow) exp_q.push_back({a[23:0], d});
            a = a + 2;
          end
        end
        kl++;
      end
    end
  endtask

  // sampled mid-cycle, well clear of the edge that launches the store
  always @(negedge clk_sys) begin
    if (mem_wr.wr === 1'b1) begin
      if (exp_q.size() == 0) chk(1, 0, "unexpected store");
      else chk({mem_wr.addr, mem_wr.data}, exp_q.pop_front(), "store");
    end
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    seed = 32'h81B4EED7;
    errors = 0;
    checks = 0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {pol, key, mask_allow} = '0;
    arst_n = 1'b0;
    step(20);
    arst_n = 1'b1;
    rd_chk(`VPC_OFS_WIN_CTRL, `VPC_RST_WIN_CTRL);
    rd_chk(`VPC_OFS_POLARITY, `VPC_RST_POLARITY);
    wr(8'hA5, 8'hFF);
    rd_chk(8'hA5, 8'h00);
    $display("register test done");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      vs = i[1:0];
      hs = i[3:2];
      {odd, slow, allow, men, hsel, vsel} = r[5:0];
      nl = 9 + r[6];
      np = 7 + 2 * r[7];
      pol = r[15:8];
      key = r[31:16];
      mb = {r2[23:1], 1'b0};
      ms = 8'(r2[31:20] / 64 + 1);
      wb = {r3[23:1], 1'b0};
      ws = r3[31:24];
      swp = r3[0];
      wr(`VPC_OFS_WIN_CTRL, 8'h00);
      wr(`VPC_OFS_PORT_STATUS, {1'b0, swp, 6'h00});
      wr(`VPC_OFS_POLARITY, pol);
      wr24(`VPC_OFS_MASK_BASE0, mb);
      wr(`VPC_OFS_MASK_STRIDE, ms);
      wr24(`VPC_OFS_WIN_BASE0, wb);
      wr(`VPC_OFS_WIN_STRIDE, ws);
      mask_allow = allow;
      rd_chk(`VPC_OFS_POLARITY, pol);
      rd_chk(`VPC_OFS_WIN_BASE1, wb[15:8]);
      rd_chk(`VPC_OFS_MASK_BASE2, mb[23:16]);
      wr(`VPC_OFS_WIN_CTRL, {men, hsel, vsel, vs, hs, 1'b1});
      expect_frame();
      src.frame(nl, np, odd, slow);
      step(8);
      chk(exp_q.size(), 0, "missing stores");
      chk(mask_line_addr, 24'(mb + 8 * ms * kl), "mask line address");
      chk(capture_active, pol[0], "capture active level");
      chk(line_kept, ((nl & ((1 << vs) - 1)) == (vsel & ((1 << vs) - 1))) ^ pol[1],
          "line kept level");
      rd_chk(`VPC_OFS_PORT_STATUS, {1'b0, swp, 4'h0, odd, 1'b0});
      $display("frame test %0d done", i);
    end
    results();
  end
endmodule
`default_nettype wire
